// file: rtl/pms_top.sv
// Power mode sequencer: active, register retention and standby control.
// Assumes firmware on an 8-bit register port and on-chip wake sources
// arriving asynchronously.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_top import pms_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Wake sources and oscillator status
  input  wire logic       pin_wake_in,
  input  wire logic       tick_in,
  input  wire logic       comp_wake_in,
  input  wire logic       radio_interrupt_in,
  input  wire logic       misc_interrupt_in,
  input  wire logic       xtal_running_in,
  // Power control
  output pms_pwr_t        power_out,
  output pms_state_t      mode_out,
  output logic            short_prestart_out
);

  // ==========================================================
  // Helpers

  // Address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Selected low-frequency source counts as running
  function automatic logic lf_active(input logic [2:0] src);
    lf_active = (src <= `PMS_LF_LAST_ACTIVE);
  endfunction

  // ==========================================================
  // Input synchronisation

  logic [5:0] sync_raw;
  pms_wake_t  w;

  pms_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({xtal_running_in, misc_interrupt_in, radio_interrupt_in,
                  comp_wake_in, tick_in, pin_wake_in}),
    .sync_out   (sync_raw)
  );

  assign w = pms_wake_t'(sync_raw);

  // ==========================================================
  // Register state

  logic [7:0]             system_clock_control;
  logic [2:0]             lf_src;
  logic [2:0]             pd_code;
  logic [2:0]             wake_flags;
  pms_state_t             state;
  logic                   timers_on;
  logic                   xtal_at_entry;
  logic [`PMS_CNT_W-1:0]  cnt;
  logic [1:0]             xsel;
  logic                   keep_xtal;

  assign xsel      = system_clock_control[`PMS_XSEL_HI:`PMS_XSEL_LO];
  assign keep_xtal = system_clock_control[`PMS_KEEP_XTAL_BIT];

  // ==========================================================
  // Decode

  logic wr_clk;
  logic wr_pd;
  logic wr_lf;
  logic rd_pd;
  logic enter_rr;
  logic enter_sb;

  assign wr_clk = wr_in && hit(addr_in, `PMS_ADDR_CLK_CTRL);
  assign wr_pd  = wr_in && hit(addr_in, `PMS_ADDR_PD_SEL);
  assign wr_lf  = wr_in && hit(addr_in, `PMS_ADDR_LF_CTRL);
  assign rd_pd  = rd_in && hit(addr_in, `PMS_ADDR_PD_SEL);

  // Mode entry on a code written as data
  assign enter_rr = (state == PMS_ACTIVE) && wr_pd &&
                    (wdata_in[2:0] == `PMS_CODE_REG_RET);  // see R10
  assign enter_sb = (state == PMS_ACTIVE) && wr_pd &&
                    (wdata_in[2:0] == `PMS_CODE_STANDBY);

  // ==========================================================
  // Wake qualification

  logic rr_wake;
  logic sb_wake;
  logic tick_wake;
  logic use_short;

  // Pin always; tick and comparator only with timers running
  assign rr_wake = w.pin | (timers_on & (w.tick | w.comp));  // see R1 see R14

  // Standby adds radio and misc, drops the comparator
  assign sb_wake = w.pin | (timers_on & w.tick) |
                   w.radio_interrupt | w.misc_interrupt;  // see R5 see R6

  assign tick_wake = timers_on & w.tick;

  // Short pre-start only after a tick with a running crystal at entry
  assign use_short = tick_wake &&
                     ((xsel == `PMS_XSEL_RC_ONLY) || keep_xtal) &&  // see R2
                     xtal_at_entry;  // see R3

  // ==========================================================
  // Clock control register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      system_clock_control <= `PMS_CLK_CTRL_RST;
    end else if (wr_clk) begin
      system_clock_control <= wdata_in;
    end
  end

  // Low-frequency source select
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      lf_src <= `PMS_LF_SRC_RST;
    end else if (wr_lf) begin
      lf_src <= wdata_in[2:0];
    end
  end

  // ==========================================================
  // Variant latch at retention or standby entry
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      timers_on     <= 1'b0;
      xtal_at_entry <= 1'b0;
    end else if (enter_rr || enter_sb) begin
      timers_on     <= lf_active(lf_src);  // see R11 see R18
      xtal_at_entry <= w.xtal_running;
    end
  end

  // ==========================================================
  // Mode sequencer
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state              <= PMS_ACTIVE;
      cnt                <= '0;
      short_prestart_out <= 1'b0;
    end else begin
      case (state)
        PMS_ACTIVE: begin
          short_prestart_out <= 1'b0;
          if (enter_rr) begin
            state <= PMS_REG_RET;  // see R10
          end else if (enter_sb) begin
            state <= PMS_STANDBY;
          end
        end
        PMS_REG_RET: begin
          if (rr_wake) begin
            state              <= PMS_WAKE;
            short_prestart_out <= use_short;
            cnt <= use_short ? `PMS_CNT_W'(`PMS_SHORT_CYC)
                             : `PMS_CNT_W'(`PMS_REGRET_CYC);  // see R2
          end
        end
        PMS_STANDBY: begin
          if (sb_wake) begin
            state <= PMS_WAKE;
            cnt   <= `PMS_CNT_W'(`PMS_STBY_CYC);  // see R8
          end
        end
        PMS_WAKE: begin
          // Return straight to execution, no system reset
          if (cnt <= `PMS_CNT_W'(1)) begin
            state <= PMS_ACTIVE;  // see R4
          end else begin
            cnt <= cnt - `PMS_CNT_W'(1);
          end
        end
        default: begin
          state <= PMS_ACTIVE;
        end
      endcase
    end
  end

  assign mode_out = state;

  // ==========================================================
  // Mode code readback
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pd_code <= `PMS_CODE_ACTIVE;
    end else if (enter_rr || enter_sb) begin
      pd_code <= wdata_in[2:0];
    end else if (state == PMS_WAKE && cnt <= `PMS_CNT_W'(1)) begin
      pd_code <= `PMS_CODE_ACTIVE;
    end
  end

  // ==========================================================
  // Wake cause flags: set wins over read clear and entry clear
  logic [2:0] flag_set;

  assign flag_set = (state == PMS_REG_RET && rr_wake) ?
                      {w.pin, tick_wake, timers_on & w.comp} :
                    (state == PMS_STANDBY && sb_wake) ?
                      {w.pin, tick_wake, 1'b0} : 3'h0;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wake_flags <= 3'h0;
    end else if (rd_pd || enter_rr || enter_sb) begin
      wake_flags <= flag_set;
    end else begin
      wake_flags <= wake_flags | flag_set;
    end
  end

  // ==========================================================
  // Power enables per state
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      power_out <= '{cpu_clk: 1'b1, voltage_regulator: 1'b1, memory: 1'b1,
                     fast_crystal_oscillator: 1'b1, fast_rc_oscillator: 1'b1,
                     low_freq_clock: 1'b1};
    end else begin
      case (state)
        PMS_REG_RET: begin
          power_out.cpu_clk                 <= 1'b0;
          power_out.voltage_regulator       <= 1'b0;
          power_out.memory                  <= 1'b0;
          power_out.fast_crystal_oscillator <= keep_xtal;  // see R16
          power_out.fast_rc_oscillator      <= 1'b0;
          power_out.low_freq_clock          <= timers_on;
        end
        PMS_STANDBY: begin
          power_out.cpu_clk                 <= 1'b0;  // see R7
          power_out.voltage_regulator       <= 1'b1;  // see R9
          power_out.memory                  <= 1'b1;
          power_out.fast_crystal_oscillator <= 1'b1;
          power_out.fast_rc_oscillator      <= 1'b0;
          power_out.low_freq_clock          <= timers_on;
        end
        PMS_WAKE: begin
          power_out.cpu_clk                 <= 1'b0;
          power_out.voltage_regulator       <= 1'b1;
          power_out.memory                  <= 1'b1;
          power_out.fast_crystal_oscillator <= (xsel != `PMS_XSEL_RC_ONLY);
          power_out.fast_rc_oscillator      <= (xsel != `PMS_XSEL_XTAL_ONLY);
          power_out.low_freq_clock          <= lf_active(lf_src);
        end
        default: begin
          power_out.cpu_clk                 <= 1'b1;  // see R13
          power_out.voltage_regulator       <= 1'b1;
          power_out.memory                  <= 1'b1;
          power_out.fast_crystal_oscillator <= (xsel != `PMS_XSEL_RC_ONLY);
          power_out.fast_rc_oscillator      <= (xsel != `PMS_XSEL_XTAL_ONLY);
          power_out.low_freq_clock          <= lf_active(lf_src);
        end
      endcase
    end
  end

  // ==========================================================
  // Read data, valid only the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (!rd_in) begin
      rdata_out <= 8'h00;
    end else if (hit(addr_in, `PMS_ADDR_CLK_CTRL)) begin
      rdata_out <= system_clock_control;
    end else if (hit(addr_in, `PMS_ADDR_PD_SEL)) begin
      rdata_out <= {wake_flags, 2'h0, pd_code};
    end else if (hit(addr_in, `PMS_ADDR_LF_CTRL)) begin
      rdata_out <= {4'h0, w.xtal_running, lf_src};  // see R17
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // Checks

  // Code 100 enters register retention
  property p_rr_entry;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_ACTIVE && wr_pd && wdata_in[2:0] == 3'h4) |=> (state == PMS_REG_RET);
  endproperty
  a_rr_entry: assert property (p_rr_entry) else $error("retention not entered"); // see R10

  // Variant latched from source select at entry
  property p_variant;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    enter_rr |=> (timers_on == ($past(lf_src) <= 3'h4));
  endproperty
  a_variant: assert property (p_variant) else $error("variant latch wrong"); // see R11

  // Tick ignored in timers-off retention
  property p_rr_tick_off;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_REG_RET && !timers_on && !w.pin) |=> (state == PMS_REG_RET);
  endproperty
  a_rr_tick_off: assert property (p_rr_tick_off) else $error("bad retention wake"); // see R1

  // Comparator alone does not end standby
  property p_sb_no_comp;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_STANDBY && !w.pin && !(timers_on && w.tick) &&
     !w.radio_interrupt && !w.misc_interrupt) |=> (state == PMS_STANDBY);
  endproperty
  a_sb_no_comp: assert property (p_sb_no_comp) else $error("standby left wrongly"); // see R6

  // Radio interrupt ends standby next cycle, back to active after ten wake cycles
  property p_sb_radio;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_STANDBY && w.radio_interrupt) |=> (state == PMS_WAKE) ##10 (state == PMS_ACTIVE);
  endproperty
  a_sb_radio: assert property (p_sb_radio) else $error("standby exit timing"); // see R5

  // Standby stops the processor clock and keeps supplies
  property p_sb_power;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_STANDBY) |=> (!power_out.cpu_clk && power_out.voltage_regulator &&
                                power_out.memory && power_out.fast_crystal_oscillator);
  endproperty
  a_sb_power: assert property (p_sb_power) else $error("standby power wrong"); // see R9

  // Crystal held in retention only by the keep bit
  property p_keep_xtal;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_REG_RET) |=> (power_out.fast_crystal_oscillator == $past(keep_xtal));
  endproperty
  a_keep_xtal: assert property (p_keep_xtal) else $error("crystal keep wrong"); // see R16

  // Short pre-start needs crystal running at entry
  property p_short;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_WAKE && short_prestart_out) |-> xtal_at_entry;
  endproperty
  a_short: assert property (p_short) else $error("short pre-start misuse"); // see R3

  // Active mode runs the processor with memory and regulator on
  property p_active;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == PMS_ACTIVE) |=> (power_out.cpu_clk && power_out.memory &&
                               power_out.voltage_regulator);
  endproperty
  a_active: assert property (p_active) else $error("active power wrong"); // see R13

  // Crystal status readback follows the synchronised input
  property p_xtal_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rd_in && addr_in == 8'hAD) |=> (rdata_out[3] == $past(w.xtal_running));
  endproperty
  a_xtal_read: assert property (p_xtal_read) else $error("status bit wrong"); // see R17

endmodule // pms_top

// file: rtl/pms_defs.svh
// Constants for the power mode sequencer: register map, fields, codes, timing.
// Assumes a 100 MHz system clock and an 8-bit register port.
// Notes on behaviour
// R1: Register retention timers-on wakes like memory retention.
// R2: Tick wake uses short pre-start in two cases.
// R3: No short pre-start if crystal was not running.
// R4: Retention wakeup resumes execution, no system reset.
// R5: Standby also wakes on radio and misc interrupts.
// R6: Standby ignores the analog wakeup comparator.
// R7: Standby stops processor clock, peripherals keep running.
// R8: Standby exit resumes after about 100 ns.
// R9: Standby keeps memories, regulator and crystal powered.
// R10: Code 100 in power-down register enters register retention.
// R11: Timers-on variant only with active low-frequency source.
// R12: Firmware enables fast RC oscillator before deep sleep.
// R13: Active mode powers everything and runs the processor; code enables oscillators per clock control, low-frequency clock per source.
// R14: Timers-on retention wakes on pin, tick, comparator.
// R15: Firmware writes the mode code into power-down register.
// R16: Keep-crystal bit holds crystal on in retention.
// R17: Crystal-active status bit shows crystal clocking system.
// R18: Low-frequency variant sampled at entry, held until wake.
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// ==========================================================
// Register addresses
`define PMS_ADDR_CLK_CTRL   8'hA3
`define PMS_ADDR_PD_SEL     8'hA4
`define PMS_ADDR_LF_CTRL    8'hAD

// ==========================================================
// Reset values and fields
`define PMS_CLK_CTRL_RST    8'h00
`define PMS_LF_SRC_RST      3'h0
`define PMS_KEEP_XTAL_BIT   7
`define PMS_XSEL_HI         5
`define PMS_XSEL_LO         4
`define PMS_XSEL_RC_ONLY    2'h1
`define PMS_XSEL_XTAL_ONLY  2'h2
`define PMS_LF_LAST_ACTIVE  3'h4

// ==========================================================
// Power-down codes
`define PMS_CODE_ACTIVE     3'h0
`define PMS_CODE_REG_RET    3'h4
`define PMS_CODE_STANDBY    3'h7

// ==========================================================
// Timing
`define PMS_CNT_W           8
`define PMS_CLK_NS          10
`define PMS_STBY_NS         100
`define PMS_REGRET_NS       2000
`define PMS_SHORT_NS        200
`define PMS_STBY_CYC        (`PMS_STBY_NS / `PMS_CLK_NS)
`define PMS_REGRET_CYC      ((`PMS_REGRET_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_SHORT_CYC       ((`PMS_SHORT_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)

`endif

// file: rtl/pms_pkg.sv
// Types for the power mode sequencer.
// Assumes pms_defs.svh is compiled alongside.
package pms_pkg;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    PMS_ACTIVE  = 4'h1,
    PMS_REG_RET = 4'h2,
    PMS_STANDBY = 4'h4,
    PMS_WAKE    = 4'h8
  } pms_state_t;

  // Synchronised wake and status inputs
  typedef struct packed {
    logic xtal_running;
    logic misc_interrupt;
    logic radio_interrupt;
    logic comp;
    logic tick;
    logic pin;
  } pms_wake_t;

  // Power and clock enables
  typedef struct packed {
    logic cpu_clk;
    logic voltage_regulator;
    logic memory;
    logic fast_crystal_oscillator;
    logic fast_rc_oscillator;
    logic low_freq_clock;
  } pms_pwr_t;

endpackage

// file: rtl/pms_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs and one system clock.
`timescale 1ns/1ps
module pms_sync (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Data
  input  wire logic [5:0] async_in,
  output logic      [5:0] sync_out
);

  logic [5:0] q1;
  logic [5:0] q2;
  logic [5:0] q3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q1 <= 6'h00;
      q2 <= 6'h00;
      q3 <= 6'h00;
    end else begin
      q1 <= async_in;
      q2 <= q1;
      q3 <= q2;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync_out <= 6'h00;
    end else begin
      sync_out <= (~(q2 ^ q3) & q3) | ((q2 ^ q3) & sync_out);
    end
  end

endmodule // pms_sync

// file: verif/pms_wake_model.sv
// Model of the on-chip wake sources and fast crystal status for the sequencer.
// Assumes the bench calls its tasks; every output changes just after a rising edge.
`timescale 1ns/1ps
module pms_wake_model import pms_pkg::*; (
  // Clock
  input  wire logic sys_clk_in,
  // Wake sources and crystal status
  output pms_wake_t  src_out
);
  // ========================================
  // Sources idle low, crystal stopped
  initial src_out <= '0;

  // Hold one source level high for n cycles, then drop it
  task automatic pulse(input int idx, input int n);
    @(posedge sys_clk_in);
    src_out[idx] <= 1'b1;
    repeat (n) @(posedge sys_clk_in);
    src_out[idx] <= 1'b0;
  endtask

  // Crystal running status is a plain level
  task automatic set_xtal(input logic v);
    @(posedge sys_clk_in);
    src_out.xtal_running <= v;
  endtask
endmodule // pms_wake_model

// file: verif/testbench.sv
// Self-checking bench for the power mode sequencer: sleep entry, wake and reads.
// Assumes pms_top, pms_wake_model, the package and the defines header are compiled.
`timescale 1ns/1ps
`include "pms_defs.svh"
module testbench import pms_pkg::*; ;
  // ========================================
  // Signals and scoreboard
  typedef struct packed {
    pms_state_t m;
    logic [5:0] p;
    logic [5:0] k;
    logic [7:0] n;
    logic       s;
  } pms_note_t;
  localparam logic [7:0] l_ret = 8'hC8;
  localparam logic [7:0] l_pre = 8'h14;
  localparam logic [7:0] l_stb = 8'h0A;
  logic       sys_clk_in = 1'b0;
  logic       rst_n_in   = 1'b0;
  logic [7:0] addr_in    = 8'h00;
  logic [7:0] wdata_in   = 8'h00;
  logic       wr_in      = 1'b0;
  logic       rd_in      = 1'b0;
  logic [7:0] rdata_out;
  pms_pwr_t   power_out;
  pms_state_t mode_out;
  logic       short_prestart_out;
  pms_wake_t  src;
  int         mismatches = 0;
  int         num_checks = 0;
  logic [7:0] rdq[$];
  pms_note_t  nq[$];

  // ========================================
  // Design and partner
  pms_top pms_top_inst (
    .sys_clk_in         (sys_clk_in),
    .rst_n_in           (rst_n_in),
    .addr_in            (addr_in),
    .wdata_in           (wdata_in),
    .wr_in              (wr_in),
    .rd_in              (rd_in),
    .rdata_out          (rdata_out),
    .pin_wake_in        (src.pin),
    .tick_in            (src.tick),
    .comp_wake_in       (src.comp),
    .radio_interrupt_in (src.radio_interrupt),
    .misc_interrupt_in  (src.misc_interrupt),
    .xtal_running_in    (src.xtal_running),
    .power_out          (power_out),
    .mode_out           (mode_out),
    .short_prestart_out (short_prestart_out)
  );
  pms_wake_model pms_wake_model_inst (
    .sys_clk_in (sys_clk_in),
    .src_out    (src)
  );

  // 100 MHz clock
  always #5 sys_clk_in = ~sys_clk_in;

  // ========================================
  // Compare, verdict and register tasks
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    rdq.push_back(e);
    @(posedge sys_clk_in);
    rd_in   <= 1'b0;
  endtask

  task automatic note(input pms_state_t m, input logic [5:0] p, input logic [5:0] k,
                      input logic [7:0] n, input logic s);
    nq.push_back('{m, p, k, n, s});
  endtask

  // ========================================
  // Output watcher: oldest note of each kind against what appears
  pms_note_t  cur;
  pms_state_t last_mode = PMS_ACTIVE;
  logic       rd_d      = 1'b0;
  logic       pend      = 1'b0;
  logic       pre_seen  = 1'b0;
  logic [7:0] wlen      = 8'h00;
  always @(negedge sys_clk_in) begin
    if (rd_d)
      cmp("read data", rdq.pop_front(), rdata_out);
    if (pend && nq.size() == 0) begin
      mismatches++;
      $display("unexpected mode: expected steady seen %h", mode_out);
    end else if (pend) begin
      cur = nq.pop_front();
      cmp("mode", {4'h0, cur.m}, {4'h0, last_mode});
      cmp("power", {2'b00, cur.p}, {2'b00, power_out & cur.k});
      if (cur.m == PMS_ACTIVE) begin
        cmp("wake length", cur.n, wlen);
        cmp("short pre-start", {7'h00, cur.s}, {7'h00, pre_seen});
      end
    end
    rd_d = rd_in & rst_n_in;
    pend = rst_n_in && (mode_out !== last_mode);
    if (pend && mode_out === PMS_WAKE) begin
      wlen     = 8'h00;
      pre_seen = 1'b0;
    end
    if (mode_out === PMS_WAKE) begin
      wlen++;
      pre_seen |= short_prestart_out;
    end
    if (rst_n_in)
      last_mode = mode_out;
  end

  // ========================================
  // One sleep and wake round; ign is a source that must not wake (6: none)
  task automatic nap(input string nm, input logic [7:0] ck, input logic [2:0] lf,
                     input logic x, input logic [2:0] code, input int ign, input int wk,
                     input logic [7:0] len, input logic pre, input logic [7:0] flg);
    int w;
    wr(`PMS_ADDR_CLK_CTRL, ck); // deep sleep is never commanded here
    wr(`PMS_ADDR_LF_CTRL, {5'h00, lf});
    pms_wake_model_inst.set_xtal(x);
    repeat (6) @(posedge sys_clk_in);
    rd(`PMS_ADDR_CLK_CTRL, ck);
    rd(`PMS_ADDR_LF_CTRL, {4'h0, x, lf});
    if (code == 3'h7)
      note(PMS_STANDBY, 6'h1C, 6'h3C, 8'h00, 1'b0);
    else
      note(PMS_REG_RET, {3'h0, ck[7], 2'h0}, 6'h3C, 8'h00, 1'b0);
    wr(`PMS_ADDR_PD_SEL, {5'h00, code});
    wr(`PMS_ADDR_PD_SEL, 8'h07);
    wr(`PMS_ADDR_LF_CTRL, 8'h07);
    if (ign < 6)
      pms_wake_model_inst.pulse(ign, 8);
    repeat (8) @(posedge sys_clk_in);
    note(PMS_WAKE, 6'h00, 6'h00, 8'h00, 1'b0);
    // Back in active: supplies on, oscillators per clock control, no low-freq source left
    note(PMS_ACTIVE, {3'h7, (ck[5:4] != `PMS_XSEL_RC_ONLY), (ck[5:4] != `PMS_XSEL_XTAL_ONLY),
                      1'b0}, 6'h3F, len, pre);
    pms_wake_model_inst.pulse(wk, 8);
    for (w = 0; w < 300 && mode_out !== PMS_ACTIVE; w++)
      @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    cmp("mode after wake", {4'h0, PMS_ACTIVE}, {4'h0, mode_out});
    rd(`PMS_ADDR_PD_SEL, flg);
    rd(`PMS_ADDR_PD_SEL, 8'h00);
    repeat (2) @(posedge sys_clk_in);
    $display("test %s done", nm);
  endtask

  // ========================================
  // Main sequence
  initial begin
    logic [2:0] r_ck;
    logic [2:0] r_lf;
    void'($urandom(35));
    r_ck = 3'($urandom_range(7, 0));
    r_lf = 3'($urandom_range(4, 0));
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(`PMS_ADDR_CLK_CTRL, 8'h00);
    rd(`PMS_ADDR_PD_SEL, 8'h00);
    rd(`PMS_ADDR_LF_CTRL, 8'h00);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00);
    $display("test reset_values done");
    wr(`PMS_ADDR_PD_SEL, 8'h05);
    wr(`PMS_ADDR_PD_SEL, 8'h01);
    wr(`PMS_ADDR_LF_CTRL, 8'hF2);
    rd(`PMS_ADDR_PD_SEL, 8'h00);
    rd(`PMS_ADDR_LF_CTRL, 8'h02);
    $display("test ignored_codes done");
    nap("pin", {5'h02, r_ck}, r_lf, 1'b0, 3'h4, 6, 0, l_ret, 1'b0, 8'h80);
    nap("tick_keep", 8'h80, 3'h0, 1'b1, 3'h4, 6, 1, l_pre, 1'b1, 8'h40);
    nap("tick_rc", 8'h10, 3'h3, 1'b1, 3'h4, 6, 1, l_pre, 1'b1, 8'h40);
    nap("tick_cold", 8'h80, 3'h0, 1'b0, 3'h4, 6, 1, l_ret, 1'b0, 8'h40);
    nap("timers_off", 8'h00, 3'h7, 1'b0, 3'h4, 1, 0, l_ret, 1'b0, 8'h80);
    nap("comp", 8'h20, 3'h4, 1'b1, 3'h4, 6, 2, l_ret, 1'b0, 8'h20);
    nap("stby_radio", 8'h00, 3'h0, 1'b1, 3'h7, 2, 3, l_stb, 1'b0, 8'h00);
    nap("stby_misc", 8'h00, 3'h0, 1'b1, 3'h7, 2, 4, l_stb, 1'b0, 8'h00);
    tally_and_finish();
  end

  // Watchdog: the tests need about 1300 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    $display("unexpected run length: expected under 20000 cycles seen 20000");
    tally_and_finish();
  end
endmodule // testbench
